// ### common/elrow_pkg.sv
package elrow_pkg;
	localparam int unsigned ELROW_STAGES = 32;
	localparam logic        ELROW_ROW_ON = 1'h1;
	localparam logic        ELROW_ROW_OFF = 1'h0;
endpackage

// ### common/elrow_stage_if.sv
`timescale 1ns/1ns
interface elrow_stage_if #(parameter int unsigned N = 32);
	logic         shift;
	logic         din;
	logic [N-1:0] stages;
	modport ctrl (output shift, output din, input stages);
	modport store (input shift, input din, output stages);
endinterface

// ### logic/elrow_row_driver.sv
`timescale 1ns/1ns
// Contract
// - Thirty-two stages, one per row output
// - Shift only on falling shift clock
// - Data enters first stage, others move along
// - Serial output shows the last stage
// - Enable gates rows by their stage bits
// - Low strobe forces every row on
// - Serial output ignores enable and strobe
module elrow_row_driver
	import elrow_pkg::*;
#(
	parameter int unsigned N = ELROW_STAGES
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	// Serial link from the display controller
	input  wire logic         shift_clk_i,
	input  wire logic         data_i,
	input  wire logic         enable_i,
	input  wire logic         strobe_b_i,
	// Row drive and cascade
	output logic [N-1:0]      row_outputs_o,
	output logic              serial_o
);
	elrow_stage_if #(.N(N)) st ();

	logic shift_clk_d;
	wire  fall_seen = shift_clk_d & ~shift_clk_i;
	assign st.shift = fall_seen;
	assign st.din   = data_i;

	elrow_shift_reg #(.N(N)) u_stages (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.st      (st)
	);

	// Shift one bit into the low end; the old top stage is dropped and the cascade shows the new top stage
	function automatic logic [N-1:0] shift_word(input logic [N-1:0] word, input logic bit_in);
		shift_word = {word[N-2:0], bit_in};
	endfunction

	// Contents the register holds after this edge, so rows and cascade
	// come out of flops without trailing the register by a cycle
	wire [N-1:0] stage_now   = fall_seen ? shift_word(st.stages, data_i) : st.stages;
	wire [N-1:0] rows_gated  = enable_i ? stage_now : {N{ELROW_ROW_OFF}};
	wire [N-1:0] next_rows   = !strobe_b_i ? {N{ELROW_ROW_ON}} : rows_gated;
	wire         next_serial = stage_now[N-1];

	// Falls seen since reset, saturating once a bit can reach the cascade
	localparam int unsigned       FILL_W   = $clog2(N + 1);
	localparam logic [FILL_W-1:0] FILL_MAX = FILL_W'(N);
	logic [FILL_W-1:0] fill_cnt;
	wire               fill_full = fill_cnt == FILL_MAX;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fill_cnt <= '0;
		end else if (fall_seen && !fill_full) begin
			fill_cnt <= fill_cnt + 1'h1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_clk_d   <= 1'h0;
			row_outputs_o <= '0;
			serial_o      <= 1'h0;
		end else begin
			shift_clk_d   <= shift_clk_i;
			row_outputs_o <= next_rows;
			serial_o      <= next_serial;
		end
	end

	a_serial_last: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		##1 serial_o == st.stages[N-1])
		else $error("serial output not last stage");
	a_strobe_all_on: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!strobe_b_i |=> &row_outputs_o)
		else $error("strobe did not force rows on");
	a_enable_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_b_i && !enable_i |=> row_outputs_o == '0)
		else $error("rows on while disabled");
	a_enable_follow: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_b_i && enable_i |=> row_outputs_o == st.stages)
		else $error("rows do not follow stages");
	a_edge_only: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!(shift_clk_d && !shift_clk_i) |=> $stable(st.stages))
		else $error("stages moved without falling edge");
	a_serial_indep: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!fall_seen |=> $stable(serial_o))
		else $error("serial changed without shift");
	a_first_stage: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fall_seen |=> st.stages[0] == $past(data_i))
		else $error("first stage missed data");
	a_serial_shift: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fall_seen |=> serial_o == $past(st.stages[N-2]))
		else $error("cascade did not take the stage below it");

	a_fall_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		fall_seen |=> st.stages == {$past(st.stages[N-2:0]), $past(data_i)})
		else $error("stages did not move on a fall");

	a_rise_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!shift_clk_d && shift_clk_i |=> $stable(st.stages))
		else $error("stages moved on a rising shift clock");

	a_low_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!shift_clk_d && !shift_clk_i |=> $stable(st.stages))
		else $error("stages moved while shift clock low");

	a_high_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		shift_clk_d && shift_clk_i |=> $stable(st.stages))
		else $error("stages moved while shift clock high");

	a_strobe_disabled: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!strobe_b_i && !enable_i |=> &row_outputs_o)
		else $error("strobe did not override enable");

	a_strobe_empty: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!strobe_b_i && st.stages == '0 && !fall_seen |=> &row_outputs_o)
		else $error("strobe did not override empty stages");

	a_top_row: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_b_i && enable_i |=> row_outputs_o[N-1] == serial_o)
		else $error("top row differs from last stage");

	a_first_row: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_b_i && enable_i && fall_seen |=> row_outputs_o[0] == $past(data_i))
		else $error("first row missed serial data");

	a_serial_strobe: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!fall_seen && $changed(strobe_b_i) |=> $stable(serial_o))
		else $error("cascade followed strobe");

	a_serial_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!fall_seen && $changed(enable_i) |=> $stable(serial_o))
		else $error("cascade followed enable");

	a_rows_only_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		strobe_b_i && enable_i |=> (row_outputs_o & ~st.stages) == '0)
		else $error("row on with a low stage");

	a_cascade_fill: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!fill_full |-> !serial_o)
		else $error("cascade high before a bit could reach it");

	for (genvar i = 1; i < N; i++) begin : g_row_move
		a_row_move: assert property (@(posedge clk_i) disable iff (!rst_b_i)
			strobe_b_i && enable_i && fall_seen |=> row_outputs_o[i] == $past(st.stages[i-1]))
			else $error("row did not take the stage below");
	end

	c_shift: cover property (@(posedge clk_i) disable iff (!rst_b_i) fall_seen && data_i);
	c_strobe: cover property (@(posedge clk_i) disable iff (!rst_b_i) !strobe_b_i);
	c_row_on: cover property (@(posedge clk_i) disable iff (!rst_b_i) strobe_b_i && enable_i && |st.stages);
	c_serial_hi: cover property (@(posedge clk_i) disable iff (!rst_b_i) serial_o);
	c_fill_full: cover property (@(posedge clk_i) disable iff (!rst_b_i) fill_full && !strobe_b_i);
endmodule

// ### logic/elrow_shift_reg.sv
`timescale 1ns/1ns
module elrow_shift_reg
	import elrow_pkg::*;
#(
	parameter int unsigned N = ELROW_STAGES
) (
	input wire logic   clk_i,
	input wire logic   rst_b_i,
	elrow_stage_if.store st
);
	logic [N-1:0] shift_stages;
	wire  [N-1:0] next_stages = {shift_stages[N-2:0], st.din};

	// No reset value is documented; cleared only for a defined start
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			shift_stages <= '0;
		end else if (st.shift) begin
			shift_stages <= next_stages;
		end
	end

	assign st.stages = shift_stages;

	a_hold_no_shift: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		!st.shift |=> shift_stages == $past(shift_stages))
		else $error("stages changed without shift");
	a_shift_move: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		st.shift |=> shift_stages == {$past(shift_stages[N-2:0]), $past(st.din)})
		else $error("shift did not advance stages");
endmodule

// ### verif/elrow_ctrl_model.sv
`timescale 1ns/1ns
module elrow_ctrl_model (
	input  wire logic clk_i,
	output logic      shift_clk_o = 1'h1,
	output logic      data_o = 1'h0
);
	// One fall per bit; data flips once its hold is over
	task automatic send(input logic d);
		@(posedge clk_i) shift_clk_o <= 1'h1;
		@(posedge clk_i) shift_clk_o <= 1'h0;
		data_o <= d;
		@(posedge clk_i) data_o <= ~d;
	endtask
endmodule

// ### verif/test_el_row_driver_shift_output.sv
`timescale 1ns/1ns
module test_el_row_driver_shift_output;
	localparam logic [31:0] PAT = 32'ha5c30f96;
	logic        clk_i = 1'h0, rst_b_i = 1'h0, enable_i = 1'h1, strobe_b_i = 1'h1;
	logic        sclk, dat, ser;
	logic [31:0] rows;
	int          error_cnt = 0, check_count = 0;
	always #50 clk_i = ~clk_i;
	elrow_ctrl_model ctrl_u (.clk_i(clk_i), .shift_clk_o(sclk), .data_o(dat));
	elrow_row_driver dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .shift_clk_i(sclk), .data_i(dat),
		.enable_i(enable_i), .strobe_b_i(strobe_b_i), .row_outputs_o(rows), .serial_o(ser));
	task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic t_load;
		for (int i = 0; i < 32; i++) ctrl_u.send(PAT[31-i]);
		@(negedge clk_i);
		chk("rows", rows, PAT);
		chk("serial", {31'h0, ser}, {31'h0, PAT[31]});
		$display("t_load done");
	endtask
	task automatic t_gate;
		@(posedge clk_i) enable_i <= 1'h0;
		repeat (2) @(negedge clk_i);
		chk("rows off", rows, 32'h0);
		@(posedge clk_i) strobe_b_i <= 1'h0;
		repeat (2) @(negedge clk_i);
		chk("rows on", rows, 32'hffffffff);
		chk("serial", {31'h0, ser}, {31'h0, PAT[31]});
		@(posedge clk_i) strobe_b_i <= 1'h1;
		enable_i <= 1'h1;
		$display("t_gate done");
	endtask
	task automatic t_hold;
		repeat (8) @(negedge clk_i);
		chk("rows held", rows, PAT);
		ctrl_u.send(1'h0);
		@(negedge clk_i);
		chk("rows", rows, {PAT[30:0], 1'h0});
		chk("serial", {31'h0, ser}, {31'h0, PAT[30]});
		$display("t_hold done");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'h1;
		t_load();
		t_gate();
		t_hold();
		finish_test();
	end
	initial begin
		#100000;
		error_cnt++;
		finish_test();
	end
endmodule
